/* File: hw/rsss_relay_map.sv */
`timescale 1ns/1ps
`default_nettype none

module rsss_relay_map (
  input wire logic scanning,
  input wire logic [1:0] setup,
  input wire logic [1:0] wire_cfg,
  input wire logic analog_bus_port,
  input wire logic [6:0] manual_relays,
  output logic [6:0] relays
);

  // ----------------------------------------------------------------
  // Scan-time relay pattern
  // ----------------------------------------------------------------
  always_comb begin
    relays = manual_relays;
    if (scanning) begin
      relays = '0;
      if (analog_bus_port) begin
        relays[rsss_pkg::RLY_LOWER_BUS] = 1'b1;
        relays[rsss_pkg::RLY_UPPER_BUS] = 1'b1;
        if (setup == rsss_pkg::RSSS_SETUP_TWO_OHM) begin
          relays[rsss_pkg::RLY_BUS_TIE] = 1'b1;
        end
        // Guard stays apart in four-wire ohms with four-wire config so the paired sense leads float.
        if (!(setup == rsss_pkg::RSSS_SETUP_FOUR_OHM &&
              wire_cfg == rsss_pkg::RSSS_WIRE_FOUR)) begin
          relays[rsss_pkg::RLY_GUARD] = 1'b1;
        end
      end
    end
  end

endmodule

`default_nettype wire

/* File: hw/rsss_top.sv */
// Functional notes
// - Hold one of four scan measurement setups.
// - No scan setup allowed in one-wire config.
// - None or volts prepares voltage measurement.
// - Two-wire ohms closes 0994 with bus port.
// - Four-wire ohms lists banks 0-3 only, pairs.
// - Four-wire ohms errors on upper bank channels.
// - Setup query returns one of four tokens.
// - Bus port option gates 0992/0993/0996 in scans.
// - Bus port affects relays only while scanning.
// - Port query returns none or analog bus.
// - Four-wire ohms in four-wire config bus scan closes 0992/0993 only.
// - Status byte flags at bits 7 to 3.
// - Enable mask 256 passes only bit 8.
// - Scan completion sets event bit 8 only.
// - Condition bit 8 never reads as set.
// - Status values are 16-bit binary weighted.
// - Event read returns contents then clears.
// - Abort leaves scan-complete flag at zero.
// - Start closes first channel; triggers advance.
`timescale 1ns/1ps
`default_nettype none

module rsss_top #(
  parameter int LIST_DEPTH = 64,
  parameter int IDX_W = 6
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic reset_cmd,
  input wire logic [1:0] wire_cfg,
  input wire logic setup_wr,
  input wire logic [1:0] setup_val,
  input wire logic port_wr,
  input wire logic port_val,
  input wire logic list_wr,
  input wire logic list_clear,
  input wire logic [2:0] list_bank,
  input wire logic [2:0] list_chan,
  input wire logic scan_start,
  input wire logic scan_trigger,
  input wire logic scan_abort,
  input wire logic [6:0] manual_relays,
  input wire logic enable_wr,
  input wire logic [15:0] enable_val,
  input wire logic event_rd,
  input wire logic cond_rd,
  input wire logic esb_in,
  input wire logic mav_in,
  input wire logic que_in,
  input wire logic rqs_in,
  output logic [2:0] setup_token,
  output logic [2:0] port_token,
  output logic [1:0] setup_state,
  output logic port_state,
  output logic setup_err,
  output logic list_err,
  output logic scanning,
  output logic [2:0] active_bank,
  output logic [2:0] active_chan,
  output logic active_pair,
  output logic [6:0] relays,
  output logic [15:0] event_data,
  output logic [15:0] cond_data,
  output logic [15:0] enable_data,
  output logic [7:0] status_byte
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic upper_bank(input logic [2:0] bank);
    upper_bank = bank[rsss_pkg::BANK_UPPER_BIT];
  endfunction

  function automatic logic [2:0] setup_tok(input logic [1:0] s);
    case (s)
      rsss_pkg::RSSS_SETUP_VOLTAGE_SETUP: setup_tok = rsss_pkg::TOK_VOLTAGE_SETUP;
      rsss_pkg::RSSS_SETUP_TWO_OHM: setup_tok = rsss_pkg::TOK_TWO_OHM;
      rsss_pkg::RSSS_SETUP_FOUR_OHM: setup_tok = rsss_pkg::TOK_FOUR_OHM;
      default: setup_tok = rsss_pkg::TOK_NONE;
    endcase
  endfunction

  // ----------------------------------------------------------------
  // Wiring input synchroniser
  // ----------------------------------------------------------------
  // Wiring comes from the card jumper logic and is treated as asynchronous.
  logic [1:0] wire_meta_ff;
  logic [1:0] wire_ff;
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      wire_meta_ff <= rsss_pkg::RSSS_WIRE_ONE;
      wire_ff <= rsss_pkg::RSSS_WIRE_ONE;
    end else begin
      wire_meta_ff <= wire_cfg;
      wire_ff <= wire_meta_ff;
    end
  end

  logic is_one_wire;
  logic is_four_ohm;
  assign is_one_wire = (wire_ff == rsss_pkg::RSSS_WIRE_ONE);
  assign is_four_ohm = (setup_state == rsss_pkg::RSSS_SETUP_FOUR_OHM);

  // ----------------------------------------------------------------
  // Scan setup and port option
  // ----------------------------------------------------------------
  // Setup writes are refused during a scan so the relay pattern cannot
  // change under a running measurement.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      setup_state <= rsss_pkg::RSSS_SETUP_NONE;
      port_state <= 1'b0;
    end else if (reset_cmd) begin
      setup_state <= rsss_pkg::RSSS_SETUP_NONE;
      port_state <= 1'b0;
    end else begin
      if (setup_wr && !scanning) begin
        // One-wire refuses every measurement setup.
        if (!is_one_wire || setup_val == rsss_pkg::RSSS_SETUP_NONE) begin
          setup_state <= setup_val;
        end
      end
      if (port_wr && !scanning) begin
        port_state <= port_val;
      end
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      setup_err <= 1'b0;
    end else begin
      setup_err <= setup_wr && is_one_wire &&
                   setup_val != rsss_pkg::RSSS_SETUP_NONE;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      setup_token <= rsss_pkg::TOK_NONE;
      port_token <= rsss_pkg::TOK_NONE;
    end else begin
      setup_token <= setup_tok(setup_state);
      port_token <= port_state ? rsss_pkg::TOK_ANALOG_BUS : rsss_pkg::TOK_NONE;
    end
  end

  // ----------------------------------------------------------------
  // Scan list
  // ----------------------------------------------------------------
  // The list is checked as it is written, so setup must already be final.
  logic [5:0] list_mem [LIST_DEPTH];
  logic [IDX_W:0] list_len_ff;
  logic [IDX_W-1:0] idx_ff;
  logic list_ok;
  assign list_ok = !(is_four_ohm && upper_bank(list_bank));

  always_ff @(posedge clk_sys) begin
    if (list_wr && list_ok && !scanning && list_len_ff < LIST_DEPTH) begin
      list_mem[list_len_ff[IDX_W-1:0]] <= {list_bank, list_chan};
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      list_len_ff <= '0;
    end else if (reset_cmd || list_clear) begin
      list_len_ff <= '0;
    end else if (list_wr && list_ok && !scanning && list_len_ff < LIST_DEPTH) begin
      list_len_ff <= list_len_ff + 1'b1;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      list_err <= 1'b0;
    end else begin
      list_err <= list_wr && !list_ok;
    end
  end

  // ----------------------------------------------------------------
  // Scan sequencing
  // ----------------------------------------------------------------
  logic scan_done;
  logic last_entry;
  assign last_entry = ({1'b0, idx_ff} + 1'b1) >= list_len_ff;
  assign scan_done = scanning && scan_trigger && !scan_abort && last_entry;

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      scanning <= 1'b0;
      idx_ff <= '0;
    end else if (reset_cmd || scan_abort) begin
      scanning <= 1'b0;
      idx_ff <= '0;
    end else if (!scanning && scan_start && list_len_ff != '0) begin
      scanning <= 1'b1;
      idx_ff <= '0;
    end else if (scanning && scan_trigger) begin
      if (last_entry) begin
        scanning <= 1'b0;
        idx_ff <= '0;
      end else begin
        idx_ff <= idx_ff + 1'b1;
      end
    end
  end

  logic [5:0] cur_entry;
  assign cur_entry = list_mem[idx_ff];

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      active_bank <= '0;
      active_chan <= '0;
      active_pair <= 1'b0;
    end else begin
      active_bank <= cur_entry[5:3];
      active_chan <= cur_entry[2:0];
      // Four-wire ohms closes the matching upper-bank channel too.
      active_pair <= scanning && is_four_ohm;
    end
  end

  // ----------------------------------------------------------------
  // Relay control
  // ----------------------------------------------------------------
  logic [6:0] relay_next;
  rsss_relay_map u_map (
    .scanning(scanning),
    .setup(setup_state),
    .wire_cfg(wire_ff),
    .analog_bus_port(port_state),
    .manual_relays(manual_relays),
    .relays(relay_next)
  );

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      relays <= '0;
    end else begin
      relays <= relay_next;
    end
  end

  // ----------------------------------------------------------------
  // Operation status
  // ----------------------------------------------------------------
  logic [15:0] event_ff;
  logic [15:0] enable_ff;

  // A completion in the same cycle as the read survives the clear.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      event_ff <= rsss_pkg::STAT_ZERO;
    end else if (scan_done) begin
      event_ff <= rsss_pkg::SCAN_DONE_WEIGHT;
    end else if (event_rd) begin
      event_ff <= rsss_pkg::STAT_ZERO;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      enable_ff <= rsss_pkg::STAT_ZERO;
    end else if (enable_wr) begin
      enable_ff <= enable_val;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      event_data <= rsss_pkg::STAT_ZERO;
      cond_data <= rsss_pkg::STAT_ZERO;
      enable_data <= rsss_pkg::STAT_ZERO;
    end else begin
      if (event_rd) begin
        event_data <= event_ff;
      end
      if (cond_rd) begin
        cond_data <= rsss_pkg::STAT_ZERO;
      end
      enable_data <= enable_ff;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      status_byte <= '0;
    end else begin
      status_byte <= '0;
      status_byte[rsss_pkg::STB_OPR] <= |(event_ff & enable_ff);
      status_byte[rsss_pkg::STB_RQS] <= rqs_in;
      status_byte[rsss_pkg::STB_ESB] <= esb_in;
      status_byte[rsss_pkg::STB_MAV] <= mav_in;
      status_byte[rsss_pkg::STB_QUE] <= que_in;
    end
  end

endmodule

`default_nettype wire

/* File: inc/rsss_pkg.sv */
package rsss_pkg;

  // ----------------------------------------------------------------
  // Scan setup and wiring encodings
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    RSSS_SETUP_NONE = 2'h0,
    RSSS_SETUP_VOLTAGE_SETUP = 2'h1,
    RSSS_SETUP_TWO_OHM = 2'h2,
    RSSS_SETUP_FOUR_OHM = 2'h3
  } rsss_setup_e;

  typedef enum logic [1:0] {
    RSSS_WIRE_ONE = 2'h0,
    RSSS_WIRE_TWO = 2'h1,
    RSSS_WIRE_THREE = 2'h2,
    RSSS_WIRE_FOUR = 2'h3
  } rsss_wire_e;

  // ----------------------------------------------------------------
  // Query tokens
  // ----------------------------------------------------------------
  localparam logic [2:0] TOK_NONE = 3'h0;
  localparam logic [2:0] TOK_VOLTAGE_SETUP = 3'h1;
  localparam logic [2:0] TOK_TWO_OHM = 3'h2;
  localparam logic [2:0] TOK_FOUR_OHM = 3'h3;
  localparam logic [2:0] TOK_ANALOG_BUS = 3'h4;

  // ----------------------------------------------------------------
  // Control relay indices (relay 099n is bit n)
  // ----------------------------------------------------------------
  localparam int RELAY_W = 7;
  localparam int RLY_HI_SEL = 0;
  localparam int RLY_CABLE = 1;
  localparam int RLY_LOWER_BUS = 2;
  localparam int RLY_UPPER_BUS = 3;
  localparam int RLY_BUS_TIE = 4;
  localparam int RLY_COM_TIE = 5;
  localparam int RLY_GUARD = 6;

  // ----------------------------------------------------------------
  // Channel address and status layout
  // ----------------------------------------------------------------
  localparam int BANK_W = 3;
  localparam int BANK_UPPER_BIT = 2;
  localparam int STAT_W = 16;
  localparam int SCAN_DONE_BIT = 8;
  localparam logic [15:0] STAT_ZERO = 16'h0000;
  localparam logic [15:0] SCAN_DONE_WEIGHT = 16'h0100;
  localparam int STB_W = 8;
  localparam int STB_QUE = 3;
  localparam int STB_MAV = 4;
  localparam int STB_ESB = 5;
  localparam int STB_RQS = 6;
  localparam int STB_OPR = 7;

endpackage

/* File: testbench/relay_scan_setup_and_status_bench.sv */
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin checks_done++; if ((g) !== (e)) begin errors++; $display("MISMATCH %s exp %h got %h", n, e, g); end end
module relay_scan_setup_and_status_bench;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic [7:0] p = 8'h00;
  logic [15:0] enable_val = 16'h0000;
  logic [6:0] manual_relays = 7'h00;
  logic esb_in = 1'b0, mav_in = 1'b0, que_in = 1'b0, rqs_in = 1'b0;
  wire logic [1:0] wire_cfg, setup_val;
  wire logic setup_wr, port_wr, port_val, list_wr;
  wire logic [2:0] list_bank, list_chan;
  logic [2:0] setup_token, port_token, active_bank, active_chan;
  logic [1:0] setup_state;
  logic port_state, setup_err, list_err, scanning, active_pair;
  logic [6:0] relays;
  logic [15:0] event_data, cond_data, enable_data;
  logic [7:0] status_byte;
  int errors = 0, checks_done = 0, se = 0, le = 0;
  logic [2:0] qb [8];
  logic [2:0] qc [8];
  rsss_host host (.clk_sys, .wire_cfg, .setup_wr, .setup_val, .port_wr, .port_val, .list_wr,
    .list_bank, .list_chan);
  rsss_top dut (.clk_sys, .rst, .reset_cmd(p[0]), .wire_cfg, .setup_wr, .setup_val, .port_wr,
    .port_val, .list_wr, .list_clear(p[1]), .list_bank, .list_chan, .scan_start(p[2]),
    .scan_trigger(p[3]), .scan_abort(p[4]), .manual_relays, .enable_wr(p[5]), .enable_val,
    .event_rd(p[6]), .cond_rd(p[7]), .esb_in, .mav_in, .que_in, .rqs_in, .setup_token,
    .port_token, .setup_state, .port_state, .setup_err, .list_err, .scanning, .active_bank,
    .active_chan, .active_pair, .relays, .event_data, .cond_data, .enable_data, .status_byte);
  initial begin
    forever #2.5 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    se += (setup_err === 1'b1);
    le += (list_err === 1'b1);
  end
  // ---
  // Helpers
  // ---
  function automatic logic [6:0] er(logic [1:0] s, logic [1:0] w, logic pt);
    er = 7'h00;
    if (pt) begin
      er = 7'h4C;
      if (w == 2'h3 && s == 2'h3) er = 7'h0C;
      if (s == 2'h2) er[4] = 1'b1;
    end
  endfunction
  task automatic w(input int n);
    repeat (n) @(negedge clk_sys);
  endtask
  task automatic pulse(input int i);
    @(negedge clk_sys) p[i] = 1'b1;
    @(negedge clk_sys) p[i] = 1'b0;
  endtask
  task automatic finish_test;
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic run(input logic [1:0] s, input logic pt, input logic [1:0] wc, input logic ab);
    int n;
    n = 1 + $urandom % 8;
    host.cfg(wc, s, pt);
    pulse(1);
    if (s == 2'h3) begin
      host.add(3'h4 + 3'($urandom % 4), 3'h0);
      w(2);
      `CHK("list_err", 1, le)
    end
    for (int k = 0; k < n; k++) begin
      qb[k] = (s == 2'h3) ? 3'($urandom % 4) : 3'($urandom);
      qc[k] = 3'($urandom);
      host.add(qb[k], qc[k]);
    end
    enable_val = 16'h0100;
    {rqs_in, esb_in, mav_in, que_in} = 4'($urandom);
    manual_relays = 7'($urandom);
    pulse(5);
    pulse(2);
    w(4);
    `CHK("relays", er(s, wc, pt), relays)
    `CHK("stb", {rqs_in, esb_in, mav_in, que_in}, status_byte[6:3])
    `CHK("enable", 16'h0100, enable_data)
    for (int k = 0; k < n; k++) begin
      `CHK("chan", {qb[k], qc[k], s == 2'h3}, {active_bank, active_chan, active_pair})
      if (ab) begin
        pulse(4);
        break;
      end
      pulse(3);
      w(3);
    end
    w(3);
    `CHK("opr", !ab, status_byte[7])
    `CHK("relays", manual_relays, relays)
    pulse(6);
    w(2);
    `CHK("event", {7'h00, !ab, 8'h00}, event_data)
    pulse(6);
    w(2);
    `CHK("event", 16'h0000, event_data)
    `CHK("opr", 1'b0, status_byte[7])
  endtask
  // ---
  // Main sequence
  // ---
  initial begin
    void'($urandom(32'hA7F31BF3));
    w(3);
    rst = 1'b0;
    w(3);
    `CHK("setup_token", rsss_pkg::TOK_NONE, setup_token)
    for (int s = 0; s < 4; s++) begin
      host.cfg(2'h3, 2'(s), 1'(s));
      `CHK("setup_token", 3'(s), setup_token)
      `CHK("port_token", s[0] ? rsss_pkg::TOK_ANALOG_BUS : rsss_pkg::TOK_NONE, port_token)
    end
    host.cfg(2'h0, rsss_pkg::RSSS_SETUP_VOLTAGE_SETUP, 1'b0);
    `CHK("setup_err", 1, se)
    `CHK("setup_token", rsss_pkg::TOK_FOUR_OHM, setup_token)
    run(2'h3, 1'b1, 2'h3, 1'b0);
    run(2'h2, 1'b1, 2'h1, 1'b0);
    run(2'h1, 1'b1, 2'h3, 1'b0);
    run(2'h0, 1'b0, 2'h3, 1'b1);
    pulse(7);
    w(2);
    `CHK("cond", 16'h0000, cond_data)
    host.cfg(2'h3, rsss_pkg::RSSS_SETUP_TWO_OHM, 1'b1);
    `CHK("tokens", {rsss_pkg::TOK_TWO_OHM, rsss_pkg::TOK_ANALOG_BUS}, {setup_token, port_token})
    pulse(0);
    w(3);
    `CHK("tokens", {rsss_pkg::TOK_NONE, rsss_pkg::TOK_NONE}, {setup_token, port_token})
    finish_test;
  end
  initial begin
    repeat (5000) @(posedge clk_sys);
    errors++;
    finish_test;
  end
endmodule
bind rsss_top rsss_checker chk (.clk_sys, .rst, .esb_in, .mav_in, .que_in, .rqs_in,
  .manual_relays, .setup_state, .port_state, .setup_token, .port_token, .scanning, .relays,
  .event_data, .cond_data, .enable_data, .status_byte);
`default_nettype wire

/* File: testbench/rsss_checker.sv */
`timescale 1ns/1ps
`default_nettype none
module rsss_checker (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic esb_in,
  input wire logic mav_in,
  input wire logic que_in,
  input wire logic rqs_in,
  input wire logic [6:0] manual_relays,
  input wire logic [1:0] setup_state,
  input wire logic port_state,
  input wire logic [2:0] setup_token,
  input wire logic [2:0] port_token,
  input wire logic scanning,
  input wire logic [6:0] relays,
  input wire logic [15:0] event_data,
  input wire logic [15:0] cond_data,
  input wire logic [15:0] enable_data,
  input wire logic [7:0] status_byte
);
  // ---
  // Port relations
  // ---
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  cond_zero_a: assert property (cond_data == 16'h0000)
    else $error("condition register shows a set bit");
  event_bits_a: assert property ((event_data & 16'hFEFF) == 16'h0000)
    else $error("event data shows an unused bit");
  stb_low_a: assert property (status_byte[2:0] == 3'h0)
    else $error("status byte low bits set");
  stb_copy_a: assert property ($stable({rqs_in, esb_in, mav_in, que_in}) [*3]
    |-> status_byte[6:3] == {rqs_in, esb_in, mav_in, que_in})
    else $error("status byte flags differ from inputs");
  opr_mask_a: assert property (!enable_data[8] [*3] |-> !status_byte[7])
    else $error("summary set with bit 8 masked");
  bus_open_a: assert property ((scanning && !port_state) [*3] |-> relays == 7'h00)
    else $error("relay closed in scan without bus port");
  idle_manual_a: assert property ((!scanning && $stable(manual_relays)) [*3]
    |-> relays == manual_relays)
    else $error("idle relays differ from manual setting");
  setup_tok_a: assert property ($stable(setup_state) [*2]
    |-> setup_token == {1'b0, setup_state})
    else $error("setup token differs from setup state");
  port_tok_a: assert property ($stable(port_state) [*2]
    |-> port_token == (port_state ? rsss_pkg::TOK_ANALOG_BUS : rsss_pkg::TOK_NONE))
    else $error("port token differs from port state");
endmodule
`default_nettype wire

/* File: testbench/rsss_host.sv */
`timescale 1ns/1ps
`default_nettype none
module rsss_host (
  input wire logic clk_sys,
  output logic [1:0] wire_cfg,
  output logic setup_wr,
  output logic [1:0] setup_val,
  output logic port_wr,
  output logic port_val,
  output logic list_wr,
  output logic [2:0] list_bank,
  output logic [2:0] list_chan
);
  initial begin
    wire_cfg = 2'h3;
    {setup_wr, setup_val, port_wr, port_val, list_wr, list_bank, list_chan} = '0;
  end
  // ---
  // Command order
  // ---
  // The wiring settles through a synchroniser, so setup waits for it.
  task automatic cfg(input logic [1:0] w, input logic [1:0] s, input logic p);
    @(negedge clk_sys) wire_cfg = w;
    repeat (3) @(negedge clk_sys);
    setup_val = s;
    setup_wr = 1'b1;
    @(negedge clk_sys) setup_wr = 1'b0;
    port_val = p;
    port_wr = 1'b1;
    @(negedge clk_sys) port_wr = 1'b0;
    repeat (2) @(negedge clk_sys);
  endtask
  // Released address lines show the inverse so a stale value cannot pass.
  task automatic add(input logic [2:0] b, input logic [2:0] c);
    @(negedge clk_sys) list_wr = 1'b1;
    list_bank = b;
    list_chan = c;
    @(negedge clk_sys) list_wr = 1'b0;
    list_bank = ~b;
    list_chan = ~c;
  endtask
endmodule
`default_nettype wire
